// *** hdl/ssw_pkg.sv ***
// package: constants for the slave watchdog and node state machine
// assumes a single 25 MHz clock domain for everything that imports it
package ssw_pkg;
  localparam int CLK_MHZ = 25;
  localparam int BASE_PERIOD_NS = 1000 / CLK_MHZ;
  localparam int TICK_EXTRA = 2;
  localparam int DEF_TIMEOUT_MS = 100;
  localparam int REG_AW = 12;
  localparam int REG_DW = 16;
  localparam logic [REG_AW-1:0] OFS_TICK_DIV = 12'h400;
  localparam logic [REG_AW-1:0] OFS_APP_COUNT = 12'h410;
  localparam logic [REG_AW-1:0] OFS_BUF_COUNT = 12'h420;
  localparam logic [REG_DW-1:0] RST_TICK_DIV = 16'h09C2;
  localparam logic [REG_DW-1:0] RST_APP_COUNT = 16'h03E8;
  localparam logic [REG_DW-1:0] RST_BUF_COUNT = 16'h03E8;
  localparam logic [REG_DW-1:0] REG_ZERO = 16'h0000;
  localparam int DEF_TIMEOUT_CYCLES =
    (int'(RST_TICK_DIV) + TICK_EXTRA) * int'(RST_BUF_COUNT);
  localparam int DEF_TIMEOUT_NS = DEF_TIMEOUT_CYCLES * BASE_PERIOD_NS;
  // requested / reported node state codes
  localparam logic [2:0] CODE_POWERUP = 3'h1;
  localparam logic [2:0] CODE_CONFIG = 3'h2;
  localparam logic [2:0] CODE_UPDATE = 3'h3;
  localparam logic [2:0] CODE_INPUTS = 3'h4;
  localparam logic [2:0] CODE_RUNNING = 3'h5;
  typedef enum logic [4:0] {
    ST_POWERUP = 5'b00001,
    ST_CONFIG = 5'b00010,
    ST_INPUTS = 5'b00100,
    ST_RUNNING = 5'b01000,
    ST_UPDATE = 5'b10000
  } ssw_state_e;
endpackage

// *** hdl/ssw_tick_div.sv ***
// file: shared watchdog tick divider
// assumes divider value comes from a register on the same clock
`timescale 1ns/1ps
module ssw_tick_div #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic [W-1:0] divider,
  output logic tick
);
  import ssw_pkg::*;
  logic [W:0] cnt_reg;
  logic [W:0] cnt_next;
  logic tick_reg;
  logic tick_next;
  logic [W:0] last;

  // one tick every divider plus two base periods [RQ9] [RQ2]
  always_comb begin
    last = {1'b0, divider} + (W+1)'(TICK_EXTRA - 1);
    tick_next = 1'b0;
    cnt_next = cnt_reg + (W+1)'(1);
    if (cnt_reg >= last) begin
      cnt_next = '0;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

  chk_tick_spacing: assert property (@(posedge clk) disable iff (!nrst)
    tick |=> !tick) else $error("watchdog ticks closer than two cycles"); // [RQ9]
endmodule

// *** hdl/ssw_watchdog.sv ***
// file: one communication watchdog counting shared ticks
// assumes tick and restart are single-cycle pulses on the same clock
`timescale 1ns/1ps
module ssw_watchdog #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic restart,
  input wire logic [W-1:0] limit,
  output logic expired
);
  import ssw_pkg::*;
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  logic exp_reg;
  logic exp_next;

  always_comb begin
    cnt_next = cnt_reg;
    exp_next = exp_reg;
    if (limit == REG_ZERO) begin
      // zero count switches the watchdog off [RQ10]
      cnt_next = '0;
      exp_next = 1'b0;
    end else if (restart) begin
      // good traffic restarts and clears the trigger [RQ5] [RQ7]
      cnt_next = '0;
      exp_next = 1'b0;
    end else if (tick && !exp_reg) begin
      // timeout is count times one tick [RQ9] [RQ6] [RQ8]
      if (cnt_reg + W'(1) >= limit) begin
        exp_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + W'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_reg <= '0;
      exp_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      exp_reg <= exp_next;
    end
  end

  assign expired = exp_reg;

  chk_restart_clears: assert property (@(posedge clk) disable iff (!nrst)
    restart |=> !expired) else $error("restart did not clear watchdog"); // [RQ7]
  chk_zero_disables: assert property (@(posedge clk) disable iff (!nrst)
    limit == REG_ZERO |=> !expired) else $error("disabled watchdog fired"); // [RQ10]
  chk_expire_on_tick: assert property (@(posedge clk) disable iff (!nrst)
    $rose(expired) |-> $past(tick) && !$past(restart))
    else $error("watchdog fired without a tick"); // [RQ6]
endmodule

// *** hdl/ssw_slave.sv ***
// file: fieldbus slave watchdogs, register file and node state machine
// assumes master and application strobes are one-cycle pulses on clk
// Overview of operation
// RQ1: two independent watchdogs, 100 ms default each
// RQ2: one shared tick divider for both watchdogs
// RQ3: separate timeout count register per watchdog
// RQ4: master writes settings only when enabled; here any reg_wr writes them, there is no enable
// RQ5: good process data exchange restarts buffer watchdog
// RQ6: buffer timeout triggers, node state unchanged
// RQ7: trigger clears only on later good access
// RQ8: application interface silence triggers its watchdog
// RQ9: timeout equals count times (divider+2) base periods
// RQ10: buffer count zero disables watchdog entirely
// RQ11: expiry drives outputs to configurable safe value
// RQ12: five node states, power-up after reset
// RQ13: power-up blocks mailbox and process data
// RQ14: master sets mailbox channels 0, 1 in power-up
// RQ15: power-up to configuration checks mailbox setup
// RQ16: configuration allows mailbox, blocks process data
// RQ17: master sets process channels from 2 in configuration
// RQ18: inputs-only entry checks setup, copies inputs first
// RQ19: inputs-only passes data, outputs held safe
// RQ20: master supplies outputs before running request
// RQ21: running copies master outputs to physical outputs
// RQ22: update state via power-up only, file transfer only
// RQ23: report state, refuse illegal transitions
`timescale 1ns/1ps
module ssw_slave #(
  parameter int DW = 8,
  parameter logic [15:0] TICK_DIV_RESET = ssw_pkg::RST_TICK_DIV,
  parameter logic [15:0] APP_COUNT_RESET = ssw_pkg::RST_APP_COUNT,
  parameter logic [15:0] BUF_COUNT_RESET = ssw_pkg::RST_BUF_COUNT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ssw_pkg::REG_AW-1:0] reg_addr,
  input wire logic [ssw_pkg::REG_DW-1:0] reg_wdata,
  output logic [ssw_pkg::REG_DW-1:0] reg_rdata,
  input wire logic state_req,
  input wire logic [2:0] state_req_code,
  input wire logic mbx_cfg_ok,
  input wire logic pd_cfg_ok,
  input wire logic clk_cfg_ok,
  input wire logic pd_exchange_ok,
  input wire logic [DW-1:0] master_out_data,
  input wire logic app_access,
  input wire logic [DW-1:0] app_in_data,
  input wire logic mbx_req,
  input wire logic mbx_is_file_transfer,
  input wire logic [DW-1:0] safe_preset,
  output logic [2:0] node_state_code,
  output logic state_ack,
  output logic state_err,
  output logic mbx_grant,
  output logic pd_allow,
  output logic [DW-1:0] phys_out,
  output logic [DW-1:0] in_buf_data,
  output logic buf_wd_expired,
  output logic app_wd_expired
);
  import ssw_pkg::*;

  function automatic logic [2:0] code_of(input ssw_state_e s);
    unique case (s)
      ST_POWERUP: code_of = CODE_POWERUP;
      ST_CONFIG: code_of = CODE_CONFIG;
      ST_INPUTS: code_of = CODE_INPUTS;
      ST_RUNNING: code_of = CODE_RUNNING;
      ST_UPDATE: code_of = CODE_UPDATE;
      default: code_of = CODE_POWERUP;
    endcase
  endfunction

  function automatic logic pd_open(input ssw_state_e s);
    pd_open = (s == ST_INPUTS) || (s == ST_RUNNING);
  endfunction

  logic [REG_DW-1:0] div_reg;
  logic [REG_DW-1:0] div_next;
  logic [REG_DW-1:0] app_cnt_reg;
  logic [REG_DW-1:0] app_cnt_next;
  logic [REG_DW-1:0] buf_cnt_reg;
  logic [REG_DW-1:0] buf_cnt_next;
  logic [REG_DW-1:0] rdata_reg;
  logic [REG_DW-1:0] rdata_next;
  logic tick;
  logic buf_restart;

  // register file, settings are whatever the master last wrote [RQ4] [RQ3] [RQ2]
  always_comb begin
    div_next = div_reg;
    app_cnt_next = app_cnt_reg;
    buf_cnt_next = buf_cnt_reg;
    rdata_next = rdata_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_TICK_DIV: div_next = reg_wdata;
        OFS_APP_COUNT: app_cnt_next = reg_wdata;
        OFS_BUF_COUNT: buf_cnt_next = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_TICK_DIV: rdata_next = div_reg;
        OFS_APP_COUNT: rdata_next = app_cnt_reg;
        OFS_BUF_COUNT: rdata_next = buf_cnt_reg;
        default: rdata_next = REG_ZERO;
      endcase
    end
  end

  // reset values give 100 ms on both watchdogs [RQ1]
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      div_reg <= TICK_DIV_RESET;
      app_cnt_reg <= APP_COUNT_RESET;
      buf_cnt_reg <= BUF_COUNT_RESET;
      rdata_reg <= REG_ZERO;
    end else begin
      div_reg <= div_next;
      app_cnt_reg <= app_cnt_next;
      buf_cnt_reg <= buf_cnt_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  ssw_tick_div #(.W(REG_DW)) u_tick (
    .clk(clk),
    .nrst(nrst),
    .divider(div_reg),
    .tick(tick)
  );

  ssw_state_e state_reg;
  ssw_state_e state_next;

  // only accepted process data restarts the buffer watchdog [RQ5]
  assign buf_restart = pd_exchange_ok && pd_open(state_reg);

  ssw_watchdog #(.W(REG_DW)) u_buf_wd (
    .clk(clk),
    .nrst(nrst),
    .tick(tick),
    .restart(buf_restart),
    .limit(buf_cnt_reg),
    .expired(buf_wd_expired)
  );

  ssw_watchdog #(.W(REG_DW)) u_app_wd (
    .clk(clk),
    .nrst(nrst),
    .tick(tick),
    .restart(app_access),
    .limit(app_cnt_reg),
    .expired(app_wd_expired)
  );

  logic ack_reg;
  logic ack_next;
  logic err_reg;
  logic err_next;
  logic [DW-1:0] inbuf_reg;
  logic [DW-1:0] inbuf_next;
  logic [DW-1:0] out_reg;
  logic [DW-1:0] out_next;
  logic [DW-1:0] latched_reg;
  logic [DW-1:0] latched_next;

  // node state machine; a watchdog expiry never changes state [RQ6] [RQ23]
  always_comb begin
    state_next = state_reg;
    ack_next = 1'b0;
    err_next = 1'b0;
    if (state_req) begin
      err_next = 1'b1;
      unique case (state_reg)
        ST_POWERUP: begin
          if (state_req_code == CODE_POWERUP) begin
            err_next = 1'b0;
          end else if (state_req_code == CODE_CONFIG && mbx_cfg_ok) begin
            state_next = ST_CONFIG; // [RQ15]
            err_next = 1'b0;
          end else if (state_req_code == CODE_UPDATE) begin
            state_next = ST_UPDATE; // [RQ22]
            err_next = 1'b0;
          end
        end
        ST_CONFIG: begin
          if (state_req_code == CODE_POWERUP || state_req_code == CODE_CONFIG) begin
            state_next = (state_req_code == CODE_POWERUP) ? ST_POWERUP : ST_CONFIG;
            err_next = 1'b0;
          end else if (state_req_code == CODE_INPUTS && pd_cfg_ok && clk_cfg_ok) begin
            state_next = ST_INPUTS; // [RQ18]
            err_next = 1'b0;
          end
        end
        ST_INPUTS: begin
          if (state_req_code == CODE_POWERUP) begin
            state_next = ST_POWERUP;
            err_next = 1'b0;
          end else if (state_req_code == CODE_CONFIG) begin
            state_next = ST_CONFIG;
            err_next = 1'b0;
          end else if (state_req_code == CODE_INPUTS) begin
            err_next = 1'b0;
          end else if (state_req_code == CODE_RUNNING) begin
            state_next = ST_RUNNING; // [RQ20]
            err_next = 1'b0;
          end
        end
        ST_RUNNING: begin
          if (state_req_code == CODE_POWERUP) begin
            state_next = ST_POWERUP;
            err_next = 1'b0;
          end else if (state_req_code == CODE_CONFIG) begin
            state_next = ST_CONFIG;
            err_next = 1'b0;
          end else if (state_req_code == CODE_INPUTS) begin
            state_next = ST_INPUTS;
            err_next = 1'b0;
          end else if (state_req_code == CODE_RUNNING) begin
            err_next = 1'b0;
          end
        end
        ST_UPDATE: begin
          if (state_req_code == CODE_POWERUP || state_req_code == CODE_UPDATE) begin
            state_next = (state_req_code == CODE_POWERUP) ? ST_POWERUP : ST_UPDATE;
            err_next = 1'b0;
          end
        end
      endcase
      ack_next = !err_next;
    end
  end

  // data paths: input snapshot, output copy and safe value [RQ11] [RQ19] [RQ21]
  always_comb begin
    inbuf_next = inbuf_reg;
    latched_next = latched_reg;
    out_next = safe_preset;
    if (state_next == ST_INPUTS && state_reg == ST_CONFIG) begin
      inbuf_next = app_in_data; // [RQ18]
    end else if (pd_open(state_reg)) begin
      inbuf_next = app_in_data; // [RQ19]
    end
    if (state_reg == ST_RUNNING && pd_exchange_ok) begin
      latched_next = master_out_data;
    end
    if (state_reg == ST_RUNNING && !buf_wd_expired) begin
      out_next = latched_next; // [RQ21]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_POWERUP; // [RQ12]
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      inbuf_reg <= '0;
      out_reg <= '0;
      latched_reg <= '0;
    end else begin
      state_reg <= state_next;
      ack_reg <= ack_next;
      err_reg <= err_next;
      inbuf_reg <= inbuf_next;
      out_reg <= out_next;
      latched_reg <= latched_next;
    end
  end

  // mailbox and process data gating per state [RQ13] [RQ16] [RQ22]
  assign mbx_grant = mbx_req && ((state_reg == ST_CONFIG) || pd_open(state_reg) ||
                     (state_reg == ST_UPDATE && mbx_is_file_transfer));
  assign pd_allow = pd_open(state_reg); // [RQ13] [RQ16]
  assign node_state_code = code_of(state_reg); // [RQ23]
  assign state_ack = ack_reg;
  assign state_err = err_reg;
  assign phys_out = out_reg;
  assign in_buf_data = inbuf_reg;

  sequence s_inputs_entry;
    state_req && state_reg == ST_CONFIG && state_req_code == CODE_INPUTS &&
      pd_cfg_ok && clk_cfg_ok;
  endsequence
  sequence s_entered_with_copy;
    state_reg == ST_INPUTS && state_ack && in_buf_data == $past(app_in_data);
  endsequence

  chk_inputs_copy: assert property (@(posedge clk) disable iff (!nrst)
    s_inputs_entry |=> s_entered_with_copy)
    else $error("inputs-only entry without input snapshot"); // [RQ18]
  chk_update_entry: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == ST_UPDATE && $past(state_reg) != ST_UPDATE |-> $past(state_reg) == ST_POWERUP)
    else $error("update state entered from wrong state"); // [RQ22]
  chk_powerup_gate: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == ST_POWERUP |-> !mbx_grant && !pd_allow)
    else $error("traffic allowed in power-up"); // [RQ13]
  chk_illegal_kept: assert property (@(posedge clk) disable iff (!nrst)
    state_err |-> state_reg == $past(state_reg))
    else $error("refused request changed state"); // [RQ23]
  chk_wd_keeps_state: assert property (@(posedge clk) disable iff (!nrst)
    $rose(buf_wd_expired) && !$past(state_req) |-> $stable(state_reg))
    else $error("watchdog expiry changed node state"); // [RQ6]
  chk_safe_outputs: assert property (@(posedge clk) disable iff (!nrst)
    $past(nrst) && ($past(state_reg) != ST_RUNNING || $past(buf_wd_expired))
    |-> phys_out == $past(safe_preset))
    else $error("outputs not in safe state"); // [RQ11]
  chk_config_gate: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == ST_CONFIG |-> !pd_allow && (mbx_grant == mbx_req))
    else $error("configuration gating wrong"); // [RQ16]
  chk_mailbox_check: assert property (@(posedge clk) disable iff (!nrst)
    state_req && state_reg == ST_POWERUP && state_req_code == CODE_CONFIG && !mbx_cfg_ok
    |=> state_reg == ST_POWERUP && state_err)
    else $error("bad mailbox setup accepted"); // [RQ15]
endmodule

// *** tb/ssw_master_model.sv ***
// file: behavioural fieldbus master driving state requests and process data
// assumes its tasks are called just after a rising clk edge
`timescale 1ns/1ps
module ssw_master_model (
  input wire logic clk,
  input wire logic state_ack,
  input wire logic state_err,
  output logic state_req,
  output logic [2:0] state_req_code,
  output logic mbx_cfg_ok,
  output logic pd_cfg_ok,
  output logic clk_cfg_ok,
  output logic pd_exchange_ok,
  output logic [7:0] master_out_data
);
  initial begin
    state_req = 1'b0;
    state_req_code = 3'h0;
    mbx_cfg_ok = 1'b0;
    pd_cfg_ok = 1'b0;
    clk_cfg_ok = 1'b0;
    pd_exchange_ok = 1'b0;
    master_out_data = 8'h00;
  end
  // mailbox channels 0 and 1 set up while in power-up
  task automatic setup_mailbox(input logic ok);
    mbx_cfg_ok = ok;
  endtask
  // process channels from 2 and clock settings set up in configuration
  task automatic setup_process(input logic ok);
    pd_cfg_ok = ok;
    clk_cfg_ok = ok;
  endtask
  // one-cycle request, answer taken after the edge, then one idle cycle
  task automatic request(input logic [2:0] code, output logic ack, output logic err);
    state_req = 1'b1;
    state_req_code = code;
    @(posedge clk);
    #1;
    ack = state_ack;
    err = state_err;
    state_req = 1'b0;
    state_req_code = ~code;
    @(posedge clk);
    #1;
  endtask
  // output data travels with the exchange, released data is inverted
  task automatic exchange(input logic [7:0] data);
    master_out_data = data;
    pd_exchange_ok = 1'b1;
    @(posedge clk);
    #1;
    pd_exchange_ok = 1'b0;
    master_out_data = ~data;
  endtask
endmodule

// *** tb/tb.sv ***
// file: self-checking bench for the slave watchdogs and node state machine
// assumes the master model file is compiled first
`timescale 1ns/1ps
module tb;
  import ssw_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [REG_AW-1:0] reg_addr = 12'h000;
  logic [REG_DW-1:0] reg_wdata = 16'h0000;
  logic app_access = 1'b0;
  logic [7:0] app_in_data = 8'h5A;
  logic mbx_req = 1'b1;
  logic mbx_is_file_transfer = 1'b0;
  logic [7:0] safe_preset = 8'h3C;
  logic state_req, mbx_cfg_ok, pd_cfg_ok, clk_cfg_ok, pd_exchange_ok;
  logic [2:0] state_req_code;
  logic [7:0] master_out_data;
  logic [REG_DW-1:0] reg_rdata;
  logic [2:0] node_state_code;
  logic state_ack, state_err, mbx_grant, pd_allow, buf_wd_expired, app_wd_expired;
  logic [7:0] phys_out, in_buf_data;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;

  ssw_slave ssw_slave_i (.clk, .nrst, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .state_req, .state_req_code, .mbx_cfg_ok, .pd_cfg_ok, .clk_cfg_ok, .pd_exchange_ok,
    .master_out_data, .app_access, .app_in_data, .mbx_req, .mbx_is_file_transfer,
    .safe_preset, .node_state_code, .state_ack, .state_err, .mbx_grant, .pd_allow,
    .phys_out, .in_buf_data, .buf_wd_expired, .app_wd_expired);
  ssw_master_model ssw_master_model_i (.clk, .state_ack, .state_err, .state_req,
    .state_req_code, .mbx_cfg_ok, .pd_cfg_ok, .clk_cfg_ok, .pd_exchange_ok,
    .master_out_data);

  always #20 clk = ~clk;

  task automatic end_of_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_errors++;
      end_of_test();
    end
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic reg_write(input logic [11:0] a, input logic [15:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic reg_check(input logic [11:0] a, input logic [15:0] exp);
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd = 1'b0;
    chk_word(reg_rdata, exp);
    @(posedge clk);
    #1;
  endtask
  task automatic req(input logic [2:0] code, input logic ok, input logic [2:0] exp_st);
    logic ack;
    logic err;
    ssw_master_model_i.request(code, ack, err);
    chk_bit(ack, ok);
    chk_bit(err, ~ok);
    chk_word(16'(node_state_code), 16'(exp_st));
  endtask
  // counts edges until the chosen flag rises, bounded by limit
  task automatic wait_flag(input logic sel, input int quiet, input int limit);
    int n;
    n = 0;
    while (n < limit && (sel ? app_wd_expired : buf_wd_expired) !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_bit(n > quiet, 1'b1);
    chk_bit(sel ? app_wd_expired : buf_wd_expired, 1'b1);
  endtask

  initial begin
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    chk_word(16'(node_state_code), 16'(CODE_POWERUP));
    chk_bit(mbx_grant, 1'b0);
    chk_bit(pd_allow, 1'b0);
    reg_check(OFS_TICK_DIV, RST_TICK_DIV);
    reg_check(OFS_APP_COUNT, RST_APP_COUNT);
    reg_check(OFS_BUF_COUNT, RST_BUF_COUNT);
    reg_check(12'h430, 16'h0000);
    reg_write(OFS_TICK_DIV, 16'h0000);
    reg_write(12'h430, 16'h00FF);
    reg_write(OFS_APP_COUNT, 16'h0003);
    reg_write(OFS_BUF_COUNT, 16'h0005);
    reg_check(OFS_TICK_DIV, 16'h0000);
    reg_check(OFS_APP_COUNT, 16'h0003);
    reg_check(OFS_BUF_COUNT, 16'h0005);
    reg_check(12'h430, 16'h0000);
    repeat (2600) @(posedge clk);
    #1;
    chk_bit(app_wd_expired, 1'b1);
    req(CODE_RUNNING, 1'b0, CODE_POWERUP);
    req(CODE_CONFIG, 1'b0, CODE_POWERUP);
    ssw_master_model_i.setup_mailbox(1'b1);
    req(CODE_CONFIG, 1'b1, CODE_CONFIG);
    chk_bit(mbx_grant, 1'b1);
    chk_bit(pd_allow, 1'b0);
    mbx_req = 1'b0;
    @(posedge clk);
    #1;
    chk_bit(mbx_grant, 1'b0);
    mbx_req = 1'b1;
    req(CODE_RUNNING, 1'b0, CODE_CONFIG);
    req(CODE_UPDATE, 1'b0, CODE_CONFIG);
    req(CODE_INPUTS, 1'b0, CODE_CONFIG);
    ssw_master_model_i.setup_process(1'b1);
    app_in_data = 8'hA7;
    req(CODE_INPUTS, 1'b1, CODE_INPUTS);
    chk_word(16'(in_buf_data), 16'h00A7);
    chk_bit(pd_allow, 1'b1);
    chk_bit(mbx_grant, 1'b1);
    app_in_data = 8'h4B;
    @(posedge clk);
    #1;
    chk_word(16'(in_buf_data), 16'h004B);
    ssw_master_model_i.exchange(8'hC3);
    chk_word(16'(phys_out), 16'(safe_preset));
    chk_bit(buf_wd_expired, 1'b0);
    req(CODE_RUNNING, 1'b1, CODE_RUNNING);
    ssw_master_model_i.exchange(8'hA5);
    chk_word(16'(phys_out), 16'h00A5);
    wait_flag(1'b0, 6, 14);
    chk_word(16'(node_state_code), 16'(CODE_RUNNING));
    safe_preset = 8'hC5;
    @(posedge clk);
    #1;
    chk_word(16'(phys_out), 16'h00C5);
    ssw_master_model_i.exchange(8'h96);
    chk_bit(buf_wd_expired, 1'b0);
    app_access = 1'b1;
    @(posedge clk);
    #1;
    app_access = 1'b0;
    chk_bit(app_wd_expired, 1'b0);
    wait_flag(1'b1, 3, 10);
    reg_write(OFS_BUF_COUNT, REG_ZERO);
    ssw_master_model_i.exchange(8'h5A);
    repeat (30) @(posedge clk);
    #1;
    chk_bit(buf_wd_expired, 1'b0);
    chk_word(16'(phys_out), 16'h005A);
    req(CODE_POWERUP, 1'b1, CODE_POWERUP);
    chk_bit(pd_allow, 1'b0);
    req(CODE_UPDATE, 1'b1, CODE_UPDATE);
    chk_bit(mbx_grant, 1'b0);
    mbx_is_file_transfer = 1'b1;
    @(posedge clk);
    #1;
    chk_bit(mbx_grant, 1'b1);
    chk_bit(pd_allow, 1'b0);
    req(CODE_INPUTS, 1'b0, CODE_UPDATE);
    end_of_test();
  end
endmodule
